// file: design/rx_status_pkg.sv
/*
  Shared constants of the receive client frame status block: register
  offsets and reset values, interrupt bit positions, error vector and
  status word bit positions, and the frame length limits.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package rx_status_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00; // Preamble passthrough enable
  localparam logic [7:0] MAXLEN_OFS = 8'h04; // Largest frame accepted
  localparam logic [7:0] ISR_OFS    = 8'h08; // Sticky events, read clears
  localparam logic [7:0] IMR_OFS    = 8'h0c; // Interrupt mask
  localparam logic [7:0] FCNT_OFS   = 8'h10; // Good and errored counts

  // Reset values
  localparam logic        CTRL_RST   = 1'b0;
  localparam logic [3:0]  ISR_RST    = 4'h0;
  localparam logic [3:0]  IMR_RST    = 4'h0;
  localparam logic [15:0] FCNT_RST   = 16'h0000;

  // Field positions
  localparam int CTRL_PRE_EN_BIT = 0;
  localparam int ISR_W           = 4;
  localparam int EV_ERR_BIT      = 0; // Frame ended with any error
  localparam int EV_RUNT_BIT     = 1; // Frame of eight bytes or less dropped
  localparam int EV_CTRL_BIT     = 2; // MAC control frame seen
  localparam int EV_OVER_BIT     = 3; // Oversized frame seen

  // Error vector bits
  localparam int ERR_W        = 6;
  localparam int ERR_MALF_BIT = 0;
  localparam int ERR_CRC_BIT  = 1;
  localparam int ERR_UNDR_BIT = 2;
  localparam int ERR_OVER_BIT = 3;
  localparam int ERR_PLEN_BIT = 4;

  // Status word bits
  localparam int ST_W         = 40;
  localparam int ST_PFC_BIT   = 39;
  localparam int ST_PAUSE_BIT = 35;
  localparam int ST_CTRL_BIT  = 34;

  // Frame layout and limits, in bytes
  localparam logic [15:0] RUNT_MAX     = 16'd8;
  localparam logic [15:0] MIN_FRAME    = 16'd64;
  localparam logic [15:0] LEN_TYPE_LIM = 16'd1536;
  localparam logic [16:0] HDR_FCS_LEN  = 17'd18;
  localparam logic [15:0] PRE_BYTES    = 16'd8;
  localparam int          TYPE_BYTE    = 12;
  localparam int          OPC_BYTE     = 14;
  localparam logic [15:0] MAC_CTRL_TYPE = 16'h8808;
  localparam logic [15:0] OPC_PAUSE    = 16'h0001;
  localparam logic [15:0] OPC_PFC      = 16'h0101;
  localparam logic [15:0] MAXLEN_RST   = 16'd1518;

endpackage

// file: design/rx_frame_status.sv
/*
  Receive client output stage of an Ethernet MAC. Takes decoded beats
  from the receive datapath, drops frames of eight bytes or less, and
  drives the client with start/end marks, empty count, preamble, a
  per-frame error vector and a qualified status word. APB slave holds
  control, limits, counters and an interrupt.
  Assumes the upstream datapath sits on CLOCK_I, never stalls, marks
  its first byte at the MSB of the beat, and reports a bad FCS on the
  last beat.
*/
`timescale 1ns/10ps

module rx_frame_status #(
  parameter bit          WIDE_100G     = 1'b0,  // 1: 512-bit wide variant
  parameter logic [15:0] MAX_FRAME_DEF = rx_status_pkg::MAXLEN_RST,
  localparam int         DW            = WIDE_100G ? 512 : 128,
  localparam int         EW            = WIDE_100G ? 6 : 4
) (
  input  wire logic          CLOCK_I,        // Receive clock
  input  wire logic          RST_N_I,        // Synchronous reset, low
  input  wire logic          IN_VALID_I,     // Upstream beat valid
  input  wire logic          IN_SOP_I,       // Upstream first beat
  input  wire logic          IN_EOP_I,       // Upstream last beat
  input  wire logic [DW-1:0] IN_DATA_I,      // Upstream beat, MSB first
  input  wire logic [EW-1:0] IN_EMPTY_I,     // Unused bytes on last beat
  input  wire logic [63:0]   IN_PREAMBLE_I,  // Preamble, with first beat
  input  wire logic          IN_CTRL_BAD_I,  // Stray control char in beat
  input  wire logic          IN_ERR_CHAR_I,  // Error char in beat
  input  wire logic          IN_FCS_BAD_I,   // FCS mismatch, last beat
  input  wire logic          PSEL_I,         // APB select
  input  wire logic          PENABLE_I,      // APB access phase
  input  wire logic          PWRITE_I,       // APB direction
  input  wire logic [7:0]    PADDR_I,        // APB byte address
  input  wire logic [31:0]   PWDATA_I,       // APB write data
  output logic [31:0]        PRDATA_O,       // APB read data
  output logic               PREADY_O,       // APB ready
  output logic               PSLVERR_O,      // APB unmapped address
  output logic               IRQ_O,          // Level interrupt
  output logic               RX_VALID_O,     // Client beat valid
  output logic               RX_SOP_O,       // Client first beat
  output logic               RX_EOP_O,       // Client last beat
  output logic [DW-1:0]      RX_DATA_O,      // Client data
  output logic [EW-1:0]      RX_EMPTY_O,     // Client empty count
  output logic [63:0]        RX_PREAMBLE_O,  // Client preamble
  output logic [5:0]         RX_ERROR_O,     // Client error vector
  output logic               RX_ST_VALID_O,  // Status word valid
  output logic [39:0]        RX_ST_DATA_O    // Status word
);

  localparam int NB = DW / 8;

  //////////////////////////////////////////////////////////////////////////
  // Parameter checks, refused at elaboration: a limit below the minimum
  // frame would flag every legal frame as oversized
  if (MAX_FRAME_DEF < rx_status_pkg::MIN_FRAME) begin : g_bad_max
    $error("MAX_FRAME_DEF below minimum frame size");
  end

  //////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic                  o_valid;
    logic                  o_sop;
    logic                  o_eop;
    logic [DW-1:0]         o_data;
    logic [EW-1:0]         o_empty;
    logic [63:0]           o_pre;
    logic [5:0]            o_err;
    logic                  o_st_valid;
    logic [39:0]           o_st;
    logic                  in_frame;
    logic [15:0]           len;
    logic                  acc_bad;
    logic                  acc_echar;
    logic [15:0]           ltype;
    logic [15:0]           opc;
    logic                  pre_en;
    logic [15:0]           max_len;
    logic [3:0]            isr;
    logic [3:0]            imr;
    logic                  irq;
    logic [15:0]           good_cnt;
    logic [15:0]           bad_cnt;
    logic                  p_ready;
    logic                  p_err;
    logic [31:0]           p_rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Byte pick, index counted from the MSB of the beat
  // Callers keep idx below NB, so the slice never leaves the beat
  function automatic logic [7:0] beat_byte(input logic [DW-1:0] d,
                                           input int idx);
    beat_byte = d[DW-1-8*idx -: 8];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Combinational next state
  always_comb begin
    logic [15:0] hofs;
    logic [15:0] nbytes;
    logic [15:0] len_now;
    logic [15:0] flen;
    logic        bad_now;
    logic        echar_now;
    logic [15:0] ltype_now;
    logic [15:0] opc_now;
    logic        runt;
    logic        e_undr;
    logic        e_over;
    logic        e_crc;
    logic        e_malf;
    logic        e_plen;
    logic        is_ctrl;
    logic        fin;
    logic [5:0]  err_v;
    logic [3:0]  ev;
    logic [3:0]  rclr;
    logic        setup;
    logic        commit;
    logic        mapped;
    logic [31:0] rmux;

    s_d = s_q;

    // Header sits after the in-band preamble when the wide variant
    // passes it through the data bus.
    hofs = (WIDE_100G && s_q.pre_en) ? rx_status_pkg::PRE_BYTES : 16'h0000;
    nbytes = IN_EOP_I ? (16'(NB) - 16'(IN_EMPTY_I)) : 16'(NB);
    len_now = (IN_SOP_I ? 16'h0000 : s_q.len) + nbytes;
    flen = (len_now > hofs) ? (len_now - hofs) : 16'h0000;

    // Frame-wide flags include the current beat
    bad_now   = (IN_SOP_I ? 1'b0 : s_q.acc_bad) | IN_CTRL_BAD_I;
    echar_now = (IN_SOP_I ? 1'b0 : s_q.acc_echar) | IN_ERR_CHAR_I;
    if (IN_SOP_I) begin
      ltype_now = {beat_byte(IN_DATA_I, rx_status_pkg::TYPE_BYTE
                             + int'(hofs)),
                   beat_byte(IN_DATA_I, rx_status_pkg::TYPE_BYTE + 1
                             + int'(hofs))};
      opc_now   = {beat_byte(IN_DATA_I, rx_status_pkg::OPC_BYTE
                             + int'(hofs)),
                   beat_byte(IN_DATA_I, rx_status_pkg::OPC_BYTE + 1
                             + int'(hofs))};
    end else begin
      ltype_now = s_q.ltype;
      opc_now   = s_q.opc;
    end

    // Runts fit in one beat, so they are known before any output
    // Upstream never splits eight bytes over two beats: one beat decides
    runt = IN_VALID_I && IN_SOP_I && IN_EOP_I
           && (flen <= rx_status_pkg::RUNT_MAX);
    fin  = IN_VALID_I && IN_EOP_I && (s_q.in_frame || IN_SOP_I)
           && !runt;

    // Error terms; only looked at when fin is high
    // Payload rule assumes an untagged header: header plus FCS is 18
    e_undr = flen < rx_status_pkg::MIN_FRAME;
    e_over = flen > s_q.max_len;
    e_crc  = IN_FCS_BAD_I || echar_now || e_undr;
    e_malf = bad_now || (WIDE_100G && echar_now);
    e_plen = !e_over && (ltype_now < rx_status_pkg::LEN_TYPE_LIM)
             && ({1'b0, flen} < ({1'b0, ltype_now}
                 + rx_status_pkg::HDR_FCS_LEN));
    is_ctrl = ltype_now == rx_status_pkg::MAC_CTRL_TYPE;

    err_v = '0;
    err_v[rx_status_pkg::ERR_MALF_BIT] = e_malf;
    err_v[rx_status_pkg::ERR_CRC_BIT]  = e_crc;
    err_v[rx_status_pkg::ERR_UNDR_BIT] = e_undr;
    err_v[rx_status_pkg::ERR_OVER_BIT] = e_over;
    err_v[rx_status_pkg::ERR_PLEN_BIT] = e_plen;

    // Client beat; data registered once, marks follow the beat
    // Data passes even on idle cycles; clients qualify it with valid
    s_d.o_valid = IN_VALID_I && !runt;
    s_d.o_sop   = IN_VALID_I && IN_SOP_I && !runt;
    s_d.o_eop   = fin;
    s_d.o_data  = IN_DATA_I;
    s_d.o_empty = fin ? IN_EMPTY_I : '0;
    s_d.o_pre   = (!WIDE_100G && s_q.pre_en && IN_VALID_I
                   && IN_SOP_I && !runt) ? IN_PREAMBLE_I
                                         : 64'h0;
    s_d.o_err   = fin ? err_v : 6'h00;

    // Status word, reserved bits held at zero
    s_d.o_st_valid = fin;
    s_d.o_st = '0;
    if (fin) begin
      s_d.o_st[rx_status_pkg::ST_CTRL_BIT]  = is_ctrl;
      s_d.o_st[rx_status_pkg::ST_PAUSE_BIT] = is_ctrl
        && (opc_now == rx_status_pkg::OPC_PAUSE);
      s_d.o_st[rx_status_pkg::ST_PFC_BIT]   = is_ctrl
        && (opc_now == rx_status_pkg::OPC_PFC);
    end

    // Frame tracking; a new start simply restarts the frame
    if (IN_VALID_I) begin
      s_d.len       = len_now;
      s_d.acc_bad   = bad_now;
      s_d.acc_echar = echar_now;
      s_d.ltype     = ltype_now;
      s_d.opc       = opc_now;
      if (IN_EOP_I) begin
        s_d.in_frame = 1'b0;
      end else if (IN_SOP_I) begin
        s_d.in_frame = 1'b1;
      end
    end

    // Counters saturate so software never sees a wrap
    if (fin) begin
      if (|err_v) begin
        if (s_q.bad_cnt != 16'hffff) begin
          s_d.bad_cnt = s_q.bad_cnt + 16'h0001;
        end
      end else if (s_q.good_cnt != 16'hffff) begin
        s_d.good_cnt = s_q.good_cnt + 16'h0001;
      end
    end

    ///////////////////////////////////////////////////////////////////////
    // APB slave: data captured in setup, ready in the access cycle
    // PSLVERR_O and PRDATA_O stand until the next setup; only their
    // value in the ready cycle means anything to the master
    setup  = PSEL_I && !PENABLE_I;
    commit = PSEL_I && PENABLE_I && s_q.p_ready;
    mapped = 1'b1;
    rmux   = 32'h0000_0000;
    case (PADDR_I)
      rx_status_pkg::CTRL_OFS: begin
        rmux[rx_status_pkg::CTRL_PRE_EN_BIT] = s_q.pre_en;
      end
      rx_status_pkg::MAXLEN_OFS: begin
        rmux[15:0] = s_q.max_len;
      end
      rx_status_pkg::ISR_OFS: begin
        rmux[3:0] = s_q.isr;
      end
      rx_status_pkg::IMR_OFS: begin
        rmux[3:0] = s_q.imr;
      end
      rx_status_pkg::FCNT_OFS: begin
        rmux = {s_q.bad_cnt, s_q.good_cnt};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    s_d.p_ready = setup;
    if (setup) begin
      s_d.p_rdata = PWRITE_I ? 32'h0000_0000 : rmux;
      s_d.p_err   = !mapped;
    end

    // Writes land only at the completing edge
    rclr = 4'h0;
    if (commit && PWRITE_I) begin
      case (PADDR_I)
        rx_status_pkg::CTRL_OFS: begin
          s_d.pre_en = PWDATA_I[rx_status_pkg::CTRL_PRE_EN_BIT];
        end
        rx_status_pkg::MAXLEN_OFS: begin
          s_d.max_len = PWDATA_I[15:0];
        end
        rx_status_pkg::IMR_OFS: begin
          s_d.imr = PWDATA_I[3:0];
        end
        default: begin
          s_d.imr = s_q.imr;
        end
      endcase
    end else if (commit && (PADDR_I == rx_status_pkg::ISR_OFS)) begin
      // Clear only what the read returned, so a later event survives
      rclr = s_q.p_rdata[3:0];
    end

    // Sticky events; setting wins over the read clear
    ev = 4'h0;
    ev[rx_status_pkg::EV_ERR_BIT]  = fin && (|err_v);
    ev[rx_status_pkg::EV_RUNT_BIT] = runt;
    ev[rx_status_pkg::EV_CTRL_BIT] = fin && is_ctrl;
    ev[rx_status_pkg::EV_OVER_BIT] = fin && e_over;
    s_d.isr = (s_q.isr & ~rclr) | ev;
    // Interrupt built from the next state so it rises with its bit
    s_d.irq = |(s_d.isr & s_d.imr);
  end

  //////////////////////////////////////////////////////////////////////////
  // State register, everything on the receive clock
  // Reset loads the limit from the parameter, so software may skip
  // programming it for standard frames
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      s_q            <= '0;
      s_q.pre_en     <= rx_status_pkg::CTRL_RST;
      s_q.max_len    <= MAX_FRAME_DEF;
      s_q.isr        <= rx_status_pkg::ISR_RST;
      s_q.imr        <= rx_status_pkg::IMR_RST;
      s_q.good_cnt   <= rx_status_pkg::FCNT_RST;
      s_q.bad_cnt    <= rx_status_pkg::FCNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register
  assign PRDATA_O      = s_q.p_rdata;
  assign PREADY_O      = s_q.p_ready;
  assign PSLVERR_O     = s_q.p_err;
  assign IRQ_O         = s_q.irq;
  assign RX_VALID_O    = s_q.o_valid;
  assign RX_SOP_O      = s_q.o_sop;
  assign RX_EOP_O      = s_q.o_eop;
  assign RX_DATA_O     = s_q.o_data;
  assign RX_EMPTY_O    = s_q.o_empty;
  assign RX_PREAMBLE_O = s_q.o_pre;
  assign RX_ERROR_O    = s_q.o_err;
  assign RX_ST_VALID_O = s_q.o_st_valid;
  assign RX_ST_DATA_O  = s_q.o_st;

endmodule // rx_frame_status

// file: tb/rx_client_model.sv
/*
  Client model: consumes every frame the block delivers and keeps what
  its end beat reported. Assumes the bench reads it after each frame.
*/
`timescale 1ns/10ps
module rx_client_model (
  input  wire logic        clk_i,   // Receive clock
  input  wire logic        rst_n_i, // Sync reset, low
  input  wire logic        sop_i,   // First beat mark
  input  wire logic        eop_i,   // Last beat mark
  input  wire logic [3:0]  emp_i,   // Empty count
  input  wire logic [63:0] pre_i,   // Preamble
  input  wire logic [5:0]  err_i,   // Error vector
  input  wire logic        stv_i,   // Status valid
  input  wire logic [39:0] st_i,    // Status word
  output logic [5:0]       err_o,   // Error of last frame
  output logic [39:0]      st_o,    // Status of last frame
  output logic [3:0]       emp_o,   // Empty of last frame
  output logic [63:0]      pre_o,   // Preamble of last frame
  output logic             one_o,   // Last frame was one beat
  output logic [7:0]       n_o      // Frames delivered
);
  //////////////////////////////
  // Error and status are trusted only on the end beat, never between
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      n_o <= 8'h00;
    end else begin
      if (sop_i) pre_o <= pre_i;
      if (eop_i) begin
        err_o <= err_i;
        st_o  <= stv_i ? st_i : 40'h0;
        emp_o <= emp_i;
        one_o <= sop_i;
        n_o   <= n_o + 8'h01;
      end
    end
  end
endmodule // rx_client_model

// file: tb/rx_frame_status_sva.sv
/*
  Assertions on the client outputs of the frame status block.
  Bound into every rx_frame_status instance; sees its ports only.
*/
`timescale 1ns/10ps
module rx_frame_status_sva #(
  parameter bit  WIDE_100G = 1'b0,
  localparam int DW        = WIDE_100G ? 512 : 128,
  localparam int EW        = WIDE_100G ? 6 : 4
) (
  input wire logic          CLOCK_I,
  input wire logic          RST_N_I,
  input wire logic          IN_VALID_I,
  input wire logic          IN_SOP_I,
  input wire logic          IN_EOP_I,
  input wire logic [DW-1:0] IN_DATA_I,
  input wire logic [EW-1:0] IN_EMPTY_I,
  input wire logic          RX_VALID_O,
  input wire logic          RX_SOP_O,
  input wire logic          RX_EOP_O,
  input wire logic [DW-1:0] RX_DATA_O,
  input wire logic [EW-1:0] RX_EMPTY_O,
  input wire logic [63:0]   RX_PREAMBLE_O,
  input wire logic [5:0]    RX_ERROR_O,
  input wire logic          RX_ST_VALID_O,
  input wire logic [39:0]   RX_ST_DATA_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  logic in_open_q;
  //////////////////////////////
  // Upstream frame open; an orphan end beat is legally ignored
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) in_open_q <= 1'b0;
    else if (IN_VALID_I && IN_EOP_I) in_open_q <= 1'b0;
    else if (IN_VALID_I && IN_SOP_I) in_open_q <= 1'b1;
  end
  chk_end_cause: assert property (RX_EOP_O |->
    RX_VALID_O && $past(IN_VALID_I && IN_EOP_I)) else $error("stray end");
  chk_first_beat: assert property (IN_VALID_I && IN_SOP_I && !IN_EOP_I
    |=> RX_SOP_O && RX_DATA_O == $past(IN_DATA_I)) else $error("first");
  chk_last_empty: assert property (IN_VALID_I && IN_EOP_I && in_open_q
    |=> RX_EOP_O && RX_EMPTY_O == $past(IN_EMPTY_I)) else $error("empty");
  chk_err_at_end: assert property (!RX_EOP_O |-> RX_ERROR_O == 6'h00)
    else $error("error vector outside end beat");
  chk_undr_crc: assert property (RX_ERROR_O[2] |-> RX_ERROR_O[1])
    else $error("undersized without crc");
  chk_over_plen: assert property (RX_ERROR_O[3] |-> !RX_ERROR_O[4])
    else $error("length error on oversized");
  chk_st_qual: assert property (!RX_ST_VALID_O |-> RX_ST_DATA_O == 40'h0)
    else $error("status without valid");
  chk_st_end: assert property (RX_ST_VALID_O |-> RX_EOP_O)
    else $error("status valid off end beat");
  chk_rsvd_zero: assert property (RX_ST_DATA_O[38:36] == 3'h0 &&
    !RX_ERROR_O[5]) else $error("reserved bit set");
  chk_pre_first: assert property (!RX_SOP_O |-> RX_PREAMBLE_O == 64'h0)
    else $error("preamble off first beat");
  cover property (RX_SOP_O && RX_EOP_O);
  cover property (RX_ERROR_O[3]);
  cover property (RX_ST_DATA_O[39]);
endmodule // rx_frame_status_sva

bind rx_frame_status rx_frame_status_sva #(.WIDE_100G(WIDE_100G)) chk_u (
  .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .IN_VALID_I(IN_VALID_I),
  .IN_SOP_I(IN_SOP_I), .IN_EOP_I(IN_EOP_I), .IN_DATA_I(IN_DATA_I),
  .IN_EMPTY_I(IN_EMPTY_I), .RX_VALID_O(RX_VALID_O), .RX_SOP_O(RX_SOP_O),
  .RX_EOP_O(RX_EOP_O), .RX_DATA_O(RX_DATA_O), .RX_EMPTY_O(RX_EMPTY_O),
  .RX_PREAMBLE_O(RX_PREAMBLE_O), .RX_ERROR_O(RX_ERROR_O),
  .RX_ST_VALID_O(RX_ST_VALID_O), .RX_ST_DATA_O(RX_ST_DATA_O));

// file: tb/rx_frame_status_test.sv
/*
  Self-checking bench of the frame status block, narrow variant.
  Assumes the client model and the bound checker are compiled first.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  error_cnt++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module rx_frame_status_test;
  localparam logic [63:0] PRE = 64'h0123456789abcdef;
  logic clk, rst_n, vld, sop, eop, cbad, echar, fbad, psel, penable;
  logic pwrite, pready, pslverr, irq, rvld, rsop, reop, stv, m_one;
  logic [127:0] dat, rdat;
  logic [3:0]   emp, remp, m_emp;
  logic [63:0]  rpre, m_pre;
  logic [5:0]   rerr, m_err;
  logic [39:0]  st, m_st;
  logic [31:0]  pwdata, prdata;
  logic [7:0]   paddr, m_n, nf;
  int           error_cnt, n_tests;
  rx_frame_status #(.WIDE_100G(1'b0)) dut_u (
    .CLOCK_I(clk), .RST_N_I(rst_n), .IN_VALID_I(vld), .IN_SOP_I(sop),
    .IN_EOP_I(eop), .IN_DATA_I(dat), .IN_EMPTY_I(emp), .IN_PREAMBLE_I(PRE),
    .IN_CTRL_BAD_I(cbad), .IN_ERR_CHAR_I(echar), .IN_FCS_BAD_I(fbad),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .IRQ_O(irq), .RX_VALID_O(rvld), .RX_SOP_O(rsop),
    .RX_EOP_O(reop), .RX_DATA_O(rdat), .RX_EMPTY_O(remp),
    .RX_PREAMBLE_O(rpre), .RX_ERROR_O(rerr), .RX_ST_VALID_O(stv),
    .RX_ST_DATA_O(st));
  rx_client_model cli_u (
    .clk_i(clk), .rst_n_i(rst_n), .sop_i(rsop), .eop_i(reop), .emp_i(remp),
    .pre_i(rpre), .err_i(rerr), .stv_i(stv), .st_i(st), .err_o(m_err),
    .st_o(m_st), .emp_o(m_emp), .pre_o(m_pre), .one_o(m_one), .n_o(m_n));
  //////////////////////////////
  // APB master; bounded wait since the slave sets its own pace
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) error_cnt++;
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // One frame; header word lands on bytes 12..15 of the first beat
  task automatic frame(input int nb, input logic [3:0] em,
      input logic [31:0] hdr, input logic [2:0] fl);
    for (int i = 0; i < nb; i++) begin
      @(posedge clk);
      {vld, sop, eop} <= {1'b1, i == 0, i == nb - 1};
      dat   <= (i == 0) ? {96'h0, hdr} : {4{i}};
      emp   <= (i == nb - 1) ? em : 4'h0;
      cbad  <= fl[0] && i == 0;
      echar <= fl[1] && i == 0;
      fbad  <= fl[2] && i == nb - 1;
    end
    @(posedge clk);
    {vld, sop, eop} <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic expect_end(input logic [5:0] e, input logic [39:0] s);
    nf = nf + 8'h01;
    `CHK("frames", nf, m_n)
    `CHK("error", e, m_err)
    `CHK("status", s, m_st)
  endtask
  //////////////////////////////
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    apb(1'b0, rx_status_pkg::CTRL_OFS, 32'h0, r, e);
    `CHK("ctrl", 32'h0, r)
    apb(1'b0, rx_status_pkg::MAXLEN_OFS, 32'h0, r, e);
    `CHK("maxlen", 32'h5ee, r)
    apb(1'b0, 8'h14, 32'h0, r, e);
    `CHK("unmapped", 1'b1, e)
  endtask
  task automatic t_short();
    frame(1, 4'h2, 32'h0800_0000, 3'h0);
    expect_end(6'h06, 40'h0);
    `CHK("one beat", 1'b1, m_one)
    frame(1, 4'h8, 32'h0800_0000, 3'h0);
    `CHK("runt", nf, m_n)
  endtask
  task automatic t_stat();
    logic [31:0] h [3] = '{32'h8808_0001, 32'h8808_0101, 32'h0800_0000};
    logic [39:0] s [3] = '{40'h0c00000000, 40'h8400000000, 40'h0};
    foreach (h[i]) begin
      frame(4, 4'h0, h[i], 3'h0);
      expect_end(6'h00, s[i]);
    end
  endtask
  task automatic t_err();
    logic [2:0] f [3] = '{3'h1, 3'h2, 3'h4};
    logic [5:0] e [3] = '{6'h01, 6'h02, 6'h02};
    foreach (f[i]) begin
      frame(5, 4'h3, 32'h0800_0000, f[i]);
      expect_end(e[i], 40'h0);
      `CHK("empty", 4'h3, m_emp)
    end
  endtask
  // A 77-byte frame against three limits, one exactly at its length
  task automatic t_len();
    logic [15:0] mx [3] = '{16'd76, 16'd77, 16'd1518};
    logic [5:0]  e [3]  = '{6'h08, 6'h10, 6'h10};
    logic [31:0] r;
    logic        x;
    foreach (mx[i]) begin
      apb(1'b1, rx_status_pkg::MAXLEN_OFS, {16'h0, mx[i]}, r, x);
      frame(5, 4'h3, 32'h0100_0000, 3'h0);
      expect_end(e[i], 40'h0);
    end
  endtask
  task automatic t_pre();
    logic [31:0] r;
    logic        x;
    apb(1'b1, rx_status_pkg::CTRL_OFS, 32'h1, r, x);
    frame(4, 4'h0, 32'h0800_0000, 3'h0);
    expect_end(6'h00, 40'h0);
    `CHK("preamble", PRE, m_pre)
    apb(1'b1, rx_status_pkg::CTRL_OFS, 32'h0, r, x);
    frame(4, 4'h0, 32'h0800_0000, 3'h0);
    expect_end(6'h00, 40'h0);
    `CHK("preamble off", 64'h0, m_pre)
  endtask
  task automatic t_irq();
    logic [31:0] r;
    logic        x;
    apb(1'b0, rx_status_pkg::ISR_OFS, 32'h0, r, x);
    `CHK("isr all", 32'hf, r)
    apb(1'b1, rx_status_pkg::IMR_OFS, 32'h2, r, x);
    frame(1, 4'h8, 32'h0, 3'h0);
    `CHK("irq set", 1'b1, irq)
    apb(1'b0, rx_status_pkg::ISR_OFS, 32'h0, r, x);
    `CHK("isr", 32'h2, r)
    repeat (2) @(posedge clk);
    `CHK("irq clear", 1'b0, irq)
    apb(1'b1, rx_status_pkg::IMR_OFS, 32'h0, r, x);
    frame(1, 4'h8, 32'h0, 3'h0);
    `CHK("irq masked", 1'b0, irq)
    // Five clean frames, seven errored ones, runts never counted
    apb(1'b0, rx_status_pkg::FCNT_OFS, 32'h0, r, x);
    `CHK("counts", 32'h0007_0005, r)
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Watchdog, far beyond the two hundred or so cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    {rst_n, vld, sop, eop, cbad, echar, fbad, psel, penable, pwrite} = '0;
    {paddr, pwdata, dat, emp} = '0;
    {error_cnt, n_tests, nf} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_short();
    t_stat();
    t_err();
    t_len();
    t_pre();
    t_irq();
    end_sim();
  end
endmodule // rx_frame_status_test
